// ---- logic/fidcg_params.svh ----
// Offsets, field positions, key words and counts of the flash key check gate
`ifndef FIDCG_PARAMS_SVH
`define FIDCG_PARAMS_SVH
// Flash addresses of the seven key bytes, reset vector and option bytes
`define FIDCG_ADDR_KEY1 20'h0FFDF
`define FIDCG_ADDR_KEY2 20'h0FFE3
`define FIDCG_ADDR_KEY3 20'h0FFEB
`define FIDCG_ADDR_KEY4 20'h0FFEF
`define FIDCG_ADDR_KEY5 20'h0FFF3
`define FIDCG_ADDR_KEY6 20'h0FFF7
`define FIDCG_ADDR_KEY7 20'h0FFFB
`define FIDCG_ADDR_VEC0 20'h0FFFC
`define FIDCG_ADDR_VEC1 20'h0FFFD
`define FIDCG_ADDR_VEC2 20'h0FFFE
`define FIDCG_ADDR_RST_OPT 20'h0FFFF
`define FIDCG_ADDR_WD_OPT 20'h0FFDB
`define FIDCG_LOAD_LAST 4'hB
`define FIDCG_KEY_LAST 3'h6
`define FIDCG_VEC_BLANK 24'hFFFFFF
// Reserved key words, first key byte in the top byte
`define FIDCG_ERASE_KEY 56'h414C6552415345
`define FIDCG_LOCK_KEY 56'h50726F74656374
// Reset option byte fields
`define FIDCG_B_WD_AUTOSTART_N 0
`define FIDCG_B_CODE_PROTECT_GATE 2
`define FIDCG_B_CODE_PROTECT_N 3
`define FIDCG_B_VDET_LEVEL_LO 4
`define FIDCG_B_VMON_RESET_START_N 6
`define FIDCG_B_CLK_SRC_GUARD_INIT_N 7
`define FIDCG_PROTECT_ON_BITS 2'h1
// Watchdog period option byte fields
`define FIDCG_B_WD_PERIOD_SEL_LO 0
`define FIDCG_B_WD_WINDOW_SEL_LO 2
`define FIDCG_WD_COUNT_0 14'h03FF
`define FIDCG_WD_COUNT_1 14'h0FFF
`define FIDCG_WD_COUNT_2 14'h1FFF
`define FIDCG_WD_COUNT_3 14'h3FFF
// Register word indices
`define FIDCG_REG_STATUS 6'h00
`define FIDCG_REG_OPTIONS 6'h01
`define FIDCG_REG_CTRL 6'h02
`define FIDCG_RESP_OKAY 2'h0
`define FIDCG_RESP_SLVERR 2'h2
`endif

// ---- logic/fidcg_pkg.sv ----
// Types of the flash key check gate
package fidcg_pkg;
    typedef enum logic [7:0] {
        ST_LOAD = 8'h01,
        ST_SETTLE = 8'h02,
        ST_WAIT_KEY = 8'h04,
        ST_CHECK = 8'h08,
        ST_ERASE = 8'h10,
        ST_OPEN = 8'h20,
        ST_DENIED = 8'h40,
        ST_LOCKED = 8'h80
    } fidcg_state_t;
endpackage : fidcg_pkg

// ---- logic/fidcg_top.sv ----
// Flash key check gate with option byte decoder and AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "fidcg_params.svh"
module fidcg_top
    import fidcg_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [19:0] flash_addr_out,
    output logic flash_rd_out,
    input wire logic [7:0] flash_data_in,
    input wire logic [7:0] rx_key_byte_in,
    input wire logic rx_key_valid_in,
    input wire logic cmd_req_in,
    output logic cmd_ack_out,
    output logic cmd_refuse_out,
    output logic serial_enable_out,
    output logic parallel_lock_out,
    output logic erase_req_out,
    input wire logic erase_done_in,
    output logic watchdog_autostart_n_out,
    output logic code_protect_on_out,
    output logic [1:0] brownout_threshold_out,
    output logic vmon_reset_start_n_out,
    output logic clk_src_guard_init_n_out,
    output logic [13:0] wd_init_count_out,
    output logic [1:0] wd_window_sel_out
);
    localparam logic [55:0] ERASE_KEY = `FIDCG_ERASE_KEY;
    localparam logic [55:0] LOCK_KEY = `FIDCG_LOCK_KEY;
    fidcg_state_t state_q, state_d;
    logic [3:0] ld_idx_q, rd_idx_q, cap_idx_q, w_strb_q;
    logic cap_vld_q, bypass_q, mismatch_q, erased_q;
    logic [7:0] st_key_q [7], rx_key_q [7];
    logic [2:0] rx_cnt_q;
    logic [23:0] vec_q;
    logic [7:0] rst_opt_q, wd_opt_q, aw_addr_q;
    logic [31:0] w_data_q;
    logic aw_full_q, w_full_q, aw_take, w_take, commit, ar_take;
    wire logic [6:0] key_eq, rx_erase_b, st_erase_b, st_lock_b;
    logic rx_erase, st_erase, st_lock, protect_on, rekey;
    logic [1:0] protect_bits;
    // Flash map of the twelve bytes fetched after reset
    function automatic logic [19:0] flash_addr_of(input logic [3:0] idx);
        case (idx)
            4'h0: flash_addr_of = `FIDCG_ADDR_KEY1;
            4'h1: flash_addr_of = `FIDCG_ADDR_KEY2;
            4'h2: flash_addr_of = `FIDCG_ADDR_KEY3;
            4'h3: flash_addr_of = `FIDCG_ADDR_KEY4;
            4'h4: flash_addr_of = `FIDCG_ADDR_KEY5;
            4'h5: flash_addr_of = `FIDCG_ADDR_KEY6;
            4'h6: flash_addr_of = `FIDCG_ADDR_KEY7;
            4'h7: flash_addr_of = `FIDCG_ADDR_VEC0;
            4'h8: flash_addr_of = `FIDCG_ADDR_VEC1;
            4'h9: flash_addr_of = `FIDCG_ADDR_VEC2;
            4'hA: flash_addr_of = `FIDCG_ADDR_RST_OPT;
            default: flash_addr_of = `FIDCG_ADDR_WD_OPT;
        endcase
    endfunction : flash_addr_of
    // Issue one flash read per cycle while loading; data returns a cycle later
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ld_idx_q <= 4'h0;
            rd_idx_q <= 4'h0;
            flash_rd_out <= 1'b0;
            flash_addr_out <= 20'h00000;
        end else if (state_q == ST_LOAD && ld_idx_q <= `FIDCG_LOAD_LAST) begin
            flash_rd_out <= 1'b1;
            flash_addr_out <= flash_addr_of(ld_idx_q);
            rd_idx_q <= ld_idx_q;
            ld_idx_q <= ld_idx_q + 4'h1;
        end else begin
            flash_rd_out <= 1'b0;
        end
    end

    // Capture pipeline; contents stay frozen until the next reset
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cap_vld_q <= 1'b0;
            cap_idx_q <= 4'h0;
            vec_q <= 24'h000000;
            rst_opt_q <= 8'hFF;
            wd_opt_q <= 8'hFF;
            for (int i = 0; i < 7; i++) begin
                st_key_q[i] <= 8'h00;
            end
        end else begin
            cap_vld_q <= flash_rd_out;
            cap_idx_q <= rd_idx_q;
            if (cap_vld_q) begin
                if (cap_idx_q <= 4'h6) begin
                    st_key_q[cap_idx_q[2:0]] <= flash_data_in;
                end else if (cap_idx_q <= 4'h9) begin
                    vec_q <= {flash_data_in, vec_q[23:8]};
                end else if (cap_idx_q == 4'hA) begin
                    rst_opt_q <= flash_data_in;
                end else begin
                    wd_opt_q <= flash_data_in;
                end
            end
        end
    end

    // Per-byte comparisons; a reserved word needs every position exact
    for (genvar gi = 0; gi < 7; gi++) begin : g_key
        assign key_eq[gi] = rx_key_q[gi] == st_key_q[gi];
        assign rx_erase_b[gi] = rx_key_q[gi] == ERASE_KEY[55 - 8 * gi -: 8];
        assign st_erase_b[gi] = st_key_q[gi] == ERASE_KEY[55 - 8 * gi -: 8];
        assign st_lock_b[gi] = st_key_q[gi] == LOCK_KEY[55 - 8 * gi -: 8];
    end
    assign rx_erase = &rx_erase_b;
    assign st_erase = &st_erase_b;
    assign st_lock = &st_lock_b;
    assign protect_bits = {rst_opt_q[`FIDCG_B_CODE_PROTECT_N], rst_opt_q[`FIDCG_B_CODE_PROTECT_GATE]};
    assign protect_on = protect_bits == `FIDCG_PROTECT_ON_BITS;
    // Rekey: CTRL bit 0 written as one restarts key entry from ST_OPEN or ST_DENIED unless bypass_q is set
    assign rekey = commit && aw_addr_q[7:2] == `FIDCG_REG_CTRL && w_strb_q[0] && w_data_q[0];
    // Gate sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_LOAD: begin
                if (cap_vld_q && cap_idx_q == `FIDCG_LOAD_LAST) begin
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (st_lock) begin
                    state_d = ST_LOCKED;
                end else if (vec_q == `FIDCG_VEC_BLANK) begin
                    state_d = ST_OPEN;
                end else begin
                    state_d = ST_WAIT_KEY;
                end
            end
            ST_WAIT_KEY: begin
                if (rx_key_valid_in && rx_cnt_q == `FIDCG_KEY_LAST) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (rx_erase && st_erase) begin
                    state_d = ST_ERASE;
                end else if (rx_erase && !st_erase && !protect_on) begin
                    state_d = ST_ERASE;
                end else if (&key_eq) begin
                    state_d = ST_OPEN;
                end else begin
                    state_d = ST_DENIED;
                end
            end
            ST_ERASE: begin
                if (erase_done_in) begin
                    state_d = ST_OPEN;
                end
            end
            ST_OPEN, ST_DENIED: begin
                if (rekey && !bypass_q) begin
                    state_d = ST_WAIT_KEY;
                end
            end
            ST_LOCKED: state_d = ST_LOCKED;
        endcase
    end
    // State register
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_LOAD;
        end else begin
            state_q <= state_d;
        end
    end
    // Received key bytes in arrival order
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_cnt_q <= 3'h0;
            for (int i = 0; i < 7; i++) begin
                rx_key_q[i] <= 8'h00;
            end
        end else if (state_q != ST_WAIT_KEY) begin
            rx_cnt_q <= 3'h0;
        end else if (rx_key_valid_in) begin
            rx_key_q[rx_cnt_q] <= rx_key_byte_in;
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    // Outcome flags; mismatch clears on rekey, erased sticks until reset, bypass decided once per reset
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bypass_q <= 1'b0;
            mismatch_q <= 1'b0;
            erased_q <= 1'b0;
        end else begin
            if (state_q == ST_SETTLE && !st_lock && vec_q == `FIDCG_VEC_BLANK) begin
                bypass_q <= 1'b1;
            end
            if (state_d == ST_DENIED && state_q == ST_CHECK) begin
                mismatch_q <= 1'b1;
            end else if (state_d == ST_WAIT_KEY) begin
                mismatch_q <= 1'b0;
            end
            if (state_q == ST_ERASE && erase_done_in) begin
                erased_q <= 1'b1;
            end
        end
    end
    // Link-side answers; a locked gate stays silent
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_ack_out <= 1'b0;
            cmd_refuse_out <= 1'b0;
            serial_enable_out <= 1'b0;
            parallel_lock_out <= 1'b0;
            erase_req_out <= 1'b0;
        end else begin
            cmd_ack_out <= cmd_req_in && state_q == ST_OPEN;
            cmd_refuse_out <= cmd_req_in && state_q != ST_OPEN && state_q != ST_LOCKED;
            serial_enable_out <= state_d != ST_LOCKED && state_d != ST_LOAD;
            parallel_lock_out <= state_d == ST_LOCKED && protect_on;
            erase_req_out <= state_d == ST_ERASE;
        end
    end

    // Option decode, latched once after loading and held until reset
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            watchdog_autostart_n_out <= 1'b1;
            code_protect_on_out <= 1'b0;
            brownout_threshold_out <= 2'h3;
            vmon_reset_start_n_out <= 1'b1;
            clk_src_guard_init_n_out <= 1'b1;
            wd_init_count_out <= `FIDCG_WD_COUNT_3;
            wd_window_sel_out <= 2'h3;
        end else if (state_q == ST_SETTLE) begin
            watchdog_autostart_n_out <= rst_opt_q[`FIDCG_B_WD_AUTOSTART_N];
            code_protect_on_out <= protect_on;
            brownout_threshold_out <= rst_opt_q[`FIDCG_B_VDET_LEVEL_LO +: 2];
            vmon_reset_start_n_out <= rst_opt_q[`FIDCG_B_VMON_RESET_START_N];
            clk_src_guard_init_n_out <= rst_opt_q[`FIDCG_B_CLK_SRC_GUARD_INIT_N];
            wd_window_sel_out <= wd_opt_q[`FIDCG_B_WD_WINDOW_SEL_LO +: 2];
            unique case (wd_opt_q[`FIDCG_B_WD_PERIOD_SEL_LO +: 2])
                2'h0: wd_init_count_out <= `FIDCG_WD_COUNT_0;
                2'h1: wd_init_count_out <= `FIDCG_WD_COUNT_1;
                2'h2: wd_init_count_out <= `FIDCG_WD_COUNT_2;
                2'h3: wd_init_count_out <= `FIDCG_WD_COUNT_3;
            endcase
        end
    end
    // AXI4-Lite write side: address and data held separately, committed together
    assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && s_axi_wready_out;
    assign commit = aw_full_q && w_full_q && !s_axi_bvalid_out;
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `FIDCG_RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_take && !(aw_full_q && !commit);
            s_axi_wready_out <= !w_take && !(w_full_q && !commit);
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end else if (commit) begin
                aw_full_q <= 1'b0;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end else if (commit) begin
                w_full_q <= 1'b0;
            end
            if (commit) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= aw_addr_q[7:2] > `FIDCG_REG_CTRL ? `FIDCG_RESP_SLVERR : `FIDCG_RESP_OKAY;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end
    // AXI4-Lite read side; stored key bytes are never readable
    assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `FIDCG_RESP_OKAY;
        end else begin
            s_axi_arready_out <= !ar_take && !(s_axi_rvalid_out && !s_axi_rready_in);
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= `FIDCG_RESP_OKAY;
                s_axi_rdata_out <= 32'h00000000;
                case (s_axi_araddr_in[7:2])
                    `FIDCG_REG_STATUS: s_axi_rdata_out <= {20'h00000, state_q == ST_WAIT_KEY,
                        rst_opt_q[1] && wd_opt_q[7:4] == 4'hF, erased_q, state_q == ST_ERASE, state_q == ST_LOCKED,
                        mismatch_q, bypass_q, state_q == ST_OPEN, state_q != ST_LOAD, rx_cnt_q};
                    `FIDCG_REG_OPTIONS: s_axi_rdata_out <= {16'h0000, wd_opt_q, rst_opt_q};
                    `FIDCG_REG_CTRL: s_axi_rdata_out <= 32'h00000000;
                    default: s_axi_rresp_out <= `FIDCG_RESP_SLVERR;
                endcase
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end
    // Checks
    sequence s_key_checked;
        state_q == ST_CHECK;
    endsequence
    sequence s_wr_both;
        aw_take && w_take && !aw_full_q && !w_full_q && !s_axi_bvalid_out;
    endsequence
    a_bypass_opens: assert property (@(posedge core_clk_in) disable iff (reset_in)
        state_q == ST_SETTLE && !st_lock && vec_q == `FIDCG_VEC_BLANK |=> ##1 state_q == ST_OPEN && bypass_q)
        else $error("blank reset vector did not open the gate");
    a_lock_silent: assert property (@(posedge core_clk_in) disable iff (reset_in)
        state_q == ST_LOCKED |=> !cmd_ack_out && !cmd_refuse_out && !serial_enable_out)
        else $error("locked gate answered the programmer");
    a_open_acks: assert property (@(posedge core_clk_in) disable iff (reset_in)
        cmd_req_in && state_q == ST_OPEN |=> cmd_ack_out && !cmd_refuse_out)
        else $error("open gate failed to acknowledge");
    a_denied_refuses: assert property (@(posedge core_clk_in) disable iff (reset_in)
        cmd_req_in && state_q == ST_DENIED |=> cmd_refuse_out && !cmd_ack_out)
        else $error("denied gate acknowledged a command");
    a_erase_both: assert property (@(posedge core_clk_in) disable iff (reset_in)
        s_key_checked and rx_erase && st_erase |=> erase_req_out && state_q == ST_ERASE)
        else $error("matching erase keys did not erase");
    a_erase_guard: assert property (@(posedge core_clk_in) disable iff (reset_in)
        s_key_checked and rx_erase && !st_erase && protect_on |=> state_q == ST_DENIED && !erase_req_out)
        else $error("protected part was force erased");
    a_stored_erase: assert property (@(posedge core_clk_in) disable iff (reset_in)
        s_key_checked and !rx_erase && st_erase |=> state_q == ST_DENIED ##1 mismatch_q)
        else $error("stored erase key accepted another key");
    a_parallel_lock: assert property (@(posedge core_clk_in) disable iff (reset_in)
        state_q == ST_LOCKED && $stable(state_q) |-> parallel_lock_out == protect_on)
        else $error("parallel lock disagrees with protection");
    a_wd_count: assert property (@(posedge core_clk_in) disable iff (reset_in)
        state_q == ST_SETTLE && wd_opt_q[1:0] == 2'h1 |=> wd_init_count_out == `FIDCG_WD_COUNT_1 [*3])
        else $error("watchdog count does not follow option byte");
    a_write_resp: assert property (@(posedge core_clk_in) disable iff (reset_in)
        s_wr_both |-> ##2 s_axi_bvalid_out)
        else $error("write response not two cycles after take");
endmodule : fidcg_top
`default_nettype wire

// ---- test/fidcg_flash_model.sv ----
// Flash array model holding key, reset vector and option bytes
`timescale 1ns/10ps
`default_nettype none
`include "fidcg_params.svh"
module fidcg_flash_model (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [19:0] addr_in,
    input wire logic [55:0] key_in,
    input wire logic [23:0] vec_in,
    input wire logic [7:0] rst_opt_in,
    input wire logic [7:0] wd_opt_in,
    output logic [7:0] data_out
);
    // Byte holds only for the cycle after a read; it toggles otherwise so a late sample shows up
    always_ff @(posedge clk_in) begin
        if (!rd_in) begin
            data_out <= ~data_out;
        end else begin
            case (addr_in)
                `FIDCG_ADDR_KEY1: data_out <= key_in[55:48];
                `FIDCG_ADDR_KEY2: data_out <= key_in[47:40];
                `FIDCG_ADDR_KEY3: data_out <= key_in[39:32];
                `FIDCG_ADDR_KEY4: data_out <= key_in[31:24];
                `FIDCG_ADDR_KEY5: data_out <= key_in[23:16];
                `FIDCG_ADDR_KEY6: data_out <= key_in[15:8];
                `FIDCG_ADDR_KEY7: data_out <= key_in[7:0];
                `FIDCG_ADDR_VEC0: data_out <= vec_in[7:0];
                `FIDCG_ADDR_VEC1: data_out <= vec_in[15:8];
                `FIDCG_ADDR_VEC2: data_out <= vec_in[23:16];
                `FIDCG_ADDR_RST_OPT: data_out <= rst_opt_in;
                `FIDCG_ADDR_WD_OPT: data_out <= wd_opt_in;
                default: data_out <= 8'hFF;
            endcase
        end
    end
endmodule : fidcg_flash_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the flash key check gate
`timescale 1ns/10ps
`default_nettype none
`include "fidcg_params.svh"
module tb;
    logic core_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic kv = 1'b0, creq = 1'b0, edone = 1'b0, awr, wr, bv, arr, rv, frd, ack, rfs, sen, plk, ereq, wan, cpo, vmn, csg;
    logic [1:0] br, rr, bt, wws, resp;
    logic [7:0] awa = 8'h00, ara = 8'h00, kb = 8'h00, fd, rst_opt, wd_opt;
    logic [31:0] wdat = 32'h0, rdat, got;
    logic [19:0] fa;
    logic [13:0] wc;
    logic [55:0] skey;
    logic [23:0] vec;
    int error_cnt = 0, checks_done = 0;
    localparam logic [55:0] EK = `FIDCG_ERASE_KEY, LK = `FIDCG_LOCK_KEY, UK = 56'h0123456789ABCD;
    typedef struct packed {logic [55:0] s, r; logic [7:0] o, o2; logic v; logic [4:0] x;} fidcg_case_t;
    // Expected x is {ack, refuse, erase request, serial enable, parallel lock}
    localparam fidcg_case_t CASES [9] = '{
        '{UK, UK, 8'hFF, 8'hFF, 1'b1, 5'b10010},
        '{UK, UK, 8'h02, 8'hF0, 1'b0, 5'b10010},
        '{UK, EK ^ 56'h1, 8'hA2, 8'hF5, 1'b0, 5'b01010},
        '{UK, EK, 8'h5B, 8'hFA, 1'b0, 5'b10110},
        '{UK, EK, 8'hF7, 8'hFF, 1'b0, 5'b01010},
        '{EK, EK, 8'hF7, 8'hF6, 1'b0, 5'b10110},
        '{EK, UK, 8'hFF, 8'hF9, 1'b0, 5'b01010},
        '{LK, LK, 8'hFF, 8'hFF, 1'b0, 5'b00000},
        '{LK, LK, 8'hF7, 8'hF3, 1'b0, 5'b00001}};
    fidcg_top u_fidcg_top (.core_clk_in(core_clk), .reset_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wdat), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .flash_addr_out(fa),
        .flash_rd_out(frd), .flash_data_in(fd), .rx_key_byte_in(kb), .rx_key_valid_in(kv), .cmd_req_in(creq),
        .cmd_ack_out(ack), .cmd_refuse_out(rfs), .serial_enable_out(sen), .parallel_lock_out(plk),
        .erase_req_out(ereq), .erase_done_in(edone), .watchdog_autostart_n_out(wan), .code_protect_on_out(cpo),
        .brownout_threshold_out(bt), .vmon_reset_start_n_out(vmn), .clk_src_guard_init_n_out(csg),
        .wd_init_count_out(wc), .wd_window_sel_out(wws));
    fidcg_flash_model u_flash (.clk_in(core_clk), .rd_in(frd), .addr_in(fa), .key_in(skey), .vec_in(vec),
        .rst_opt_in(rst_opt), .wd_opt_in(wd_opt), .data_out(fd));
    always #25 core_clk = ~core_clk;
    // Cuts a hung handshake short; the whole run needs far less
    initial begin
        #200us;
        error_cnt++;
        end_sim();
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // Reset with new flash contents, wait out the load, then check the decoded options
    task automatic boot(input logic [55:0] k, input logic v, input logic [7:0] o, input logic [7:0] o2);
        logic [13:0] wce;
        wce = o2[1] ? (o2[0] ? 14'h3FFF : 14'h1FFF) : (o2[0] ? 14'h0FFF : 14'h03FF);
        skey <= k;
        vec <= {24{v}};
        rst_opt <= o;
        wd_opt <= o2;
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(20);
        chk("options", {o[7:4], ~o[3] & o[2], o[0], o2[3:2], wce}, {csg, vmn, bt, cpo, wan, wws, wc});
    endtask : boot
    task automatic send_key(input logic [55:0] k);
        for (int i = 6; i >= 0; i--) begin
            @(posedge core_clk);
            kb <= k[8*i +: 8];
            kv <= 1'b1;
        end
        @(posedge core_clk);
        kv <= 1'b0;
        tick(3);
    endtask : send_key
    // One command pulse; any answer in the next three cycles is collected
    task automatic cmd(input logic [1:0] e, input string n);
        logic [1:0] s;
        s = 2'b00;
        @(posedge core_clk);
        creq <= 1'b1;
        @(posedge core_clk);
        creq <= 1'b0;
        repeat (3) begin
            @(posedge core_clk);
            s = s | {ack, rfs};
        end
        chk(n, e, s);
    endtask : cmd
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awa <= a;
        wdat <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        fork
            begin
                do @(posedge core_clk); while (awr !== 1'b1);
                awv <= 1'b0;
            end
            begin
                do @(posedge core_clk); while (wr !== 1'b1);
                wv <= 1'b0;
            end
        join
        while (bv !== 1'b1) @(posedge core_clk);
        r = br;
        bry <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge core_clk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge core_clk);
        d = rdat;
        r = rr;
        rry <= 1'b0;
    endtask : rd_reg
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        // Each case boots its own flash image and plays one key and one command
        foreach (CASES[i]) begin
            boot(CASES[i].s, CASES[i].v, CASES[i].o, CASES[i].o2);
            send_key(CASES[i].r);
            chk("gate outputs", CASES[i].x[2:0], {ereq, sen, plk});
            if (CASES[i].x[2]) begin
                edone <= 1'b1;
                tick(1);
                edone <= 1'b0;
                tick(2);
            end
            cmd(CASES[i].x[4:3], "command answer");
        end
        // Refused key, rekey through the control register, then the right key
        boot(UK, 1'b0, 8'h02, 8'hF0);
        send_key(~UK);
        cmd(2'b01, "refused before rekey");
        rd_reg(8'h00, got, resp);
        chk("status denied", 32'h00000448, got);
        wr_reg(8'h08, 32'h1, resp);
        chk("ctrl write resp", 2'h0, resp);
        send_key(UK);
        cmd(2'b10, "ack after rekey");
        rd_reg(8'h00, got, resp);
        chk("status open", 32'h00000418, got);
        rd_reg(8'h04, got, resp);
        chk("options register", {16'h0, 8'hF0, 8'h02}, got);
        rd_reg(8'h0C, got, resp);
        chk("unmapped read resp", 2'h2, resp);
        wr_reg(8'h0C, 32'h1, resp);
        chk("unmapped write resp", 2'h2, resp);
        end_sim();
    end
endmodule : tb
`default_nettype wire
